// [rtl/adc_pkg.sv]
// Package for the asynchronous DRAM controller: pin groups, timing counts.
// Assumes a 40 MHz clock; timing counts are derived from times in ns, us or ms.
package adc_pkg;

    // Clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 25;

    // Geometry of the memory.
    localparam int ADDR_W  = 14;
    localparam int HALF_W  = 7;
    localparam int DATA_W  = 4;
    localparam int ROWS    = 128;

    // Power-up pause and wake cycles.
    localparam int WAKE_PAUSE_US = 100;
    localparam int WAKE_PAUSE_CYC = (WAKE_PAUSE_US * 1000 + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    localparam int WAKE_CYCLES   = 8;

    // Refresh period; one row refresh every period/rows, rounded down.
    localparam int REFRESH_MS    = 2;
    localparam int REFRESH_CYC   = (REFRESH_MS * 1000000 / ROWS)
                                   / CLK_PERIOD_NS;

    // Strobe phase timing (slowest grade), rounded up to whole cycles.
    localparam int ROW_PRECHARGE_NS = 120;
    localparam int ROW_PULSE_NS     = 200;
    localparam int ROW_TO_COLUMN_DELAY_NS = 30;
    localparam int COLUMN_ACCESS_TIME_NS  = 100;
    localparam int ROW_ACCESS_TIME_NS     = 200;
    localparam int WRITE_PULSE_NS   = 55;
    localparam int PAGE_PRECHARGE_NS = 70;

    localparam int T_RP  = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
    localparam int T_RAS = (ROW_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROW_TO_COLUMN_DELAY = (ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
    // Column access carries two more cycles for the data synchroniser.
    localparam int COLUMN_ACCESS_TIME = (COLUMN_ACCESS_TIME_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS + 2;
    localparam int T_WP  = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
    localparam int T_CP  = (PAGE_PRECHARGE_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;

    // Width of the general phase counter.
    localparam int CNT_W = 13;

    // Reset value of the refresh row pointer.
    localparam logic [HALF_W-1:0] ROW_PTR_RST = 7'h00;

    // Pins toward the memory; strobes are active low.
    typedef struct packed {
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic              oe_n;
        logic [HALF_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe_n;
    } adc_pins_t;

    // Request from the user side.
    typedef struct packed {
        logic              write;
        logic              page;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } adc_req_t;

    // Controller states.
    typedef enum logic [3:0] {
        ST_PAUSE   = 4'h0,
        ST_WAKE_HI = 4'h1,
        ST_WAKE_LO = 4'h2,
        ST_IDLE    = 4'h3,
        ST_ROW     = 4'h4,
        ST_COL     = 4'h5,
        ST_HOLD    = 4'h6,
        ST_PAGE    = 4'h7,
        ST_CPRE    = 4'h8,
        ST_PRE     = 4'h9,
        ST_REF     = 4'hA
    } adc_state_t;

endpackage : adc_pkg

// [rtl/adc_sync.sv]
// Two-flip-flop synchroniser for the data pins read back from the memory.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module adc_sync
    import adc_pkg::*;
(
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    // Pin side and synchronised side.
    input  wire logic [DATA_W-1:0] d_i,
    output logic      [DATA_W-1:0] q_o
);

    logic [DATA_W-1:0] meta_q;   // First stage, read only by the second.
    logic [DATA_W-1:0] sync_q;   // Second stage, safe for logic.

    // Both stages reset to zero; nothing reads the first stage but the second.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
        end
        else
        begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule : adc_sync
`default_nettype wire

// [rtl/adc_ctrl.sv]
// Controller for a 16K x 4 asynchronous DRAM: wake sequence, random and
// page accesses, and row-strobe-only refresh. Assumes the memory pins are
// wired directly, and that the data pins are resolved by the surroundings.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Row half with row strobe, then column.
// - Refresh all 128 rows every 2 ms.
// - Wait 100 us, then eight row cycles.
// - Write enable held inactive after reads.
module adc_ctrl
    import adc_pkg::*;
#(
    parameter int PAUSE_CYC = WAKE_PAUSE_CYC,
    parameter int REF_CYC   = REFRESH_CYC
)
(
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    // User request: valid/ready handshake.
    input  wire logic              req_valid_i,
    input  var  adc_req_t          req_i,
    output logic                   req_ready_o,
    // Read answer.
    output logic                   rd_valid_o,
    output logic [DATA_W-1:0]      rd_data_o,
    // Status.
    output logic                   init_done_o,
    // Memory pins; dq_oe_n is low while the controller drives data.
    output var  adc_pins_t         mem_o,
    input  wire logic [DATA_W-1:0] mem_dq_i
);

    // Whole module state in one packed struct.
    typedef struct packed {
        adc_state_t          st;
        logic [CNT_W-1:0]    cnt;       // Phase timer.
        logic [CNT_W-1:0]    ref_cnt;   // Refresh interval timer.
        logic                ref_due;   // A row refresh is owed.
        logic [HALF_W-1:0]   row_ptr;   // Next row to refresh.
        logic [3:0]          wake_n;    // Wake cycles left.
        logic                init_done;
        adc_req_t            req;       // Latched request.
        logic [HALF_W-1:0]   open_row;  // Row held open in page mode.
        adc_pins_t           pins;
        logic                rd_valid;
        logic [DATA_W-1:0]   rd_data;
    } adc_state_s_t;

    adc_state_s_t s_q;
    adc_state_s_t s_d;
    logic [DATA_W-1:0] dq_sync;  // Data pins after two flip-flops.
    logic              accept;   // Request taken this cycle.

    // Data read back from the pins is asynchronous and is synchronised.
    adc_sync u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (mem_dq_i),
        .q_o     (dq_sync)
    );

    // Ready only when idle or in an open page of the same row, with no
    // refresh owed; refresh therefore has priority over user traffic.
    assign req_ready_o = s_q.init_done && !s_q.ref_due &&
                         ((s_q.st == ST_IDLE) ||
                          ((s_q.st == ST_PAGE) &&
                           (req_i.addr[ADDR_W-1:HALF_W] == s_q.open_row)));
    assign accept = req_valid_i && req_ready_o;

    // Next-state logic for every field of the state.
    always_comb
    begin
        s_d = s_q;
        s_d.rd_valid = 1'b0;
        // Interval timer marks one row refresh owed per period.
        if (s_q.ref_cnt >= CNT_W'(REF_CYC - 1))
        begin
            s_d.ref_cnt = '0;
            s_d.ref_due = s_q.init_done;
        end
        else
        begin
            s_d.ref_cnt = s_q.ref_cnt + 13'h0001;
        end
        unique case (s_q.st)
            // Power-up pause with every strobe high.
            ST_PAUSE:
            begin
                if (s_q.cnt >= CNT_W'(PAUSE_CYC - 1))
                begin
                    s_d.st  = ST_WAKE_LO;
                    s_d.cnt = '0;
                end
                else
                begin
                    s_d.cnt = s_q.cnt + 13'h0001;
                end
            end
            // Eight row-strobe-only cycles wake the array.
            ST_WAKE_LO:
            begin
                s_d.pins.ras_n = 1'b0;
                s_d.pins.addr  = s_q.row_ptr;
                s_d.cnt = s_q.cnt + 13'h0001;
                // The strobe falls one edge after entry, so count one more.
                if (s_q.cnt >= CNT_W'(T_RAS))
                begin
                    s_d.pins.ras_n = 1'b1;
                    s_d.cnt = '0;
                    s_d.st  = ST_WAKE_HI;
                    s_d.wake_n = s_q.wake_n - 4'h1;
                end
            end
            ST_WAKE_HI:
            begin
                s_d.cnt = s_q.cnt + 13'h0001;
                if (s_q.cnt >= CNT_W'(T_RP - 1))
                begin
                    s_d.cnt = '0;
                    if (s_q.wake_n == 4'h0)
                    begin
                        s_d.st = ST_IDLE;
                        s_d.init_done = 1'b1;
                    end
                    else
                    begin
                        s_d.st = ST_WAKE_LO;
                    end
                end
            end
            // Idle: refresh first, then a user access.
            ST_IDLE:
            begin
                s_d.cnt = '0;
                if (s_q.ref_due)
                begin
                    s_d.st = ST_REF;
                    s_d.pins.addr  = s_q.row_ptr;
                    s_d.pins.ras_n = 1'b0;
                end
                else if (accept)
                begin
                    s_d.req = req_i;
                    s_d.st  = ST_ROW;
                    s_d.open_row   = req_i.addr[ADDR_W-1:HALF_W];
                    s_d.pins.addr  = req_i.addr[ADDR_W-1:HALF_W];
                    s_d.pins.ras_n = 1'b0;
                end
            end
            // Row strobe low; hold the row address, then move to column.
            ST_ROW:
            begin
                s_d.cnt = s_q.cnt + 13'h0001;
                if (s_q.cnt >= CNT_W'(ROW_TO_COLUMN_DELAY - 1))
                begin
                    // Column strobe at or after the minimum delay; any lag
                    // only moves access onto column timing.
                    s_d.cnt = '0;
                    s_d.st  = ST_COL;
                    s_d.pins.addr  = s_q.req.addr[HALF_W-1:0];
                    s_d.pins.cas_n = 1'b0;
                    if (s_q.req.write)
                    begin
                        // Early write: data and write enable change on the same edge as the
                        // column strobe, so output stays off.
                        s_d.pins.we_n    = 1'b0;
                        s_d.pins.dq_out  = s_q.req.wdata;
                        s_d.pins.dq_oe_n = 1'b0;
                    end
                    else
                    begin
                        s_d.pins.oe_n = 1'b0;
                    end
                end
            end
            // Column strobe low for access or write pulse.
            ST_COL:
            begin
                s_d.cnt = s_q.cnt + 13'h0001;
                if (s_q.cnt >= CNT_W'(COLUMN_ACCESS_TIME - 1))
                begin
                    s_d.cnt = '0;
                    s_d.st  = ST_HOLD;
                    if (!s_q.req.write)
                    begin
                        // The two extra cycles cover the synchroniser.
                        s_d.rd_data  = dq_sync;
                        s_d.rd_valid = 1'b1;
                    end
                end
            end
            // End the column phase; write enable high, outputs released.
            ST_HOLD:
            begin
                s_d.pins.cas_n   = 1'b1;
                s_d.pins.oe_n    = 1'b1;
                s_d.pins.we_n    = 1'b1;
                s_d.pins.dq_oe_n = 1'b1;
                s_d.cnt = '0;
                s_d.st  = s_q.req.page ? ST_CPRE : ST_PRE;
            end
            // Column precharge inside the open row, then wait in page.
            ST_CPRE:
            begin
                s_d.cnt = s_q.cnt + 13'h0001;
                if (s_q.cnt >= CNT_W'(T_CP - 1))
                begin
                    s_d.st = ST_PAGE;
                end
            end
            // Page open: row strobe stays low for further columns.
            ST_PAGE:
            begin
                s_d.cnt = '0;
                if (accept)
                begin
                    s_d.req = req_i;
                    s_d.st  = ST_COL;
                    s_d.pins.addr  = req_i.addr[HALF_W-1:0];
                    s_d.pins.cas_n = 1'b0;
                    if (req_i.write)
                    begin
                        s_d.pins.we_n    = 1'b0;
                        s_d.pins.dq_out  = req_i.wdata;
                        s_d.pins.dq_oe_n = 1'b0;
                    end
                    else
                    begin
                        s_d.pins.oe_n = 1'b0;
                    end
                end
                else if (!req_valid_i || s_q.ref_due ||
                         !req_i.page || !req_ready_o)
                begin
                    // Close the row when the stream ends or refresh is owed.
                    s_d.pins.ras_n = 1'b1;
                    s_d.st = ST_PRE;
                end
            end
            // Row-strobe-only refresh of one row, column strobe high.
            ST_REF:
            begin
                s_d.cnt = s_q.cnt + 13'h0001;
                s_d.ref_due = 1'b0;
                if (s_q.cnt >= CNT_W'(T_RAS - 1))
                begin
                    s_d.pins.ras_n = 1'b1;
                    s_d.row_ptr = s_q.row_ptr + 7'h01;
                    s_d.cnt = '0;
                    s_d.st  = ST_PRE;
                end
            end
            // Row precharge before the next row cycle.
            ST_PRE:
            begin
                s_d.pins.ras_n = 1'b1;
                s_d.cnt = s_q.cnt + 13'h0001;
                if (s_q.cnt >= CNT_W'(T_RP - 1))
                begin
                    s_d.cnt = '0;
                    s_d.st  = ST_IDLE;
                end
            end
            default:
            begin
                s_d.st = ST_PAUSE;
            end
        endcase
        // A refresh owed in the same cycle it was begun is kept owed.
        if (s_q.ref_cnt >= CNT_W'(REF_CYC - 1) && s_q.init_done)
        begin
            s_d.ref_due = 1'b1;
        end
    end

    // State register; strobes idle high and data pins released at reset.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_q <= '0;
            s_q.st           <= ST_PAUSE;
            s_q.wake_n       <= 4'(WAKE_CYCLES);
            s_q.row_ptr      <= ROW_PTR_RST;
            s_q.pins.ras_n   <= 1'b1;
            s_q.pins.cas_n   <= 1'b1;
            s_q.pins.we_n    <= 1'b1;
            s_q.pins.oe_n    <= 1'b1;
            s_q.pins.dq_oe_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register.
    assign mem_o       = s_q.pins;
    assign rd_valid_o  = s_q.rd_valid;
    assign rd_data_o   = s_q.rd_data;
    assign init_done_o = s_q.init_done;

endmodule : adc_ctrl
`default_nettype wire

// [sim/adc_chk_props.sv]
// Checker for the DRAM controller, watching only its ports.
// Assumes one clock, clk_i, and the active-low reset rst_b_i.
`timescale 1ns/100ps
`default_nettype none
module adc_chk
    import adc_pkg::*;
#(
    parameter int PAUSE_CYC = 10,
    parameter int REF_CYC   = 100
)
(
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    // User side.
    input  wire logic              req_valid_i,
    input  var  adc_req_t          req_i,
    input  wire logic              req_ready_o,
    input  wire logic              rd_valid_o,
    input  wire logic [DATA_W-1:0] rd_data_o,
    input  wire logic              init_done_o,
    // Memory side.
    input  var  adc_pins_t         mem_o,
    input  wire logic [DATA_W-1:0] mem_dq_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    logic [15:0] age_q, age_d;  // Cycles since reset.
    logic [15:0] gap_q, gap_d;  // Cycles the row strobe stayed high.
    logic        take;          // Request taken with no row open.

    assign take = req_valid_i && req_ready_o && mem_o.ras_n;

    // Both counters saturate, so a long idle spell cannot wrap them.
    always_comb
    begin
        age_d = age_q + {15'h0000, age_q != 16'hFFFF};
        gap_d = 16'h0000;
        if (mem_o.ras_n)
        begin
            gap_d = gap_q + {15'h0000, gap_q != 16'hFFFF};
        end
    end

    // Counter registers.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            age_q <= 16'h0000;
            gap_q <= 16'h0000;
        end
        else
        begin
            age_q <= age_d;
            gap_q <= gap_d;
        end
    end

    AST_PAUSE: assert property (
        age_q < PAUSE_CYC - 1 |-> mem_o.ras_n)
        else $error("row strobe active during power-up pause");
    AST_INIT_READY: assert property (
        !init_done_o |-> !req_ready_o)
        else $error("request accepted before wake-up ended");
    AST_ROW_FIRST: assert property (
        take |=> !mem_o.ras_n
            && mem_o.addr == $past(req_i.addr[ADDR_W-1:HALF_W]))
        else $error("row half not presented with row strobe");
    AST_COL_AFTER_ROW: assert property (
        $fell(mem_o.cas_n) |-> !mem_o.ras_n
            && $past(mem_o.ras_n, 2) == 1'b0)
        else $error("column strobe too soon after row strobe");
    AST_READ_TIME: assert property (
        take && !req_i.write |-> ##9 rd_valid_o)
        else $error("read data not delivered on time");
    AST_WRITE_QUIET: assert property (
        take && req_i.write |=> (!rd_valid_o) [*8])
        else $error("write produced read data");
    AST_EARLY_WRITE: assert property (
        $fell(mem_o.cas_n) && !mem_o.we_n |-> !mem_o.dq_oe_n && mem_o.oe_n)
        else $error("early write without data or with outputs on");
    AST_READ_WE: assert property (
        !mem_o.oe_n |-> mem_o.we_n && mem_o.dq_oe_n)
        else $error("data driven while memory outputs enabled");
    AST_WE_AFTER_READ: assert property (
        $rose(mem_o.cas_n) && $past(mem_o.oe_n) == 1'b0 |-> mem_o.we_n)
        else $error("write enable active at end of read");
    AST_REFRESH_DUE: assert property (
        init_done_o |-> gap_q < REF_CYC + 32)
        else $error("row strobe idle too long for refresh");
    AST_RD_PULSE: assert property (
        rd_valid_o |=> !rd_valid_o)
        else $error("read valid longer than one cycle");

    COV_READ: cover property (take && !req_i.write);
    COV_WRITE: cover property (take && req_i.write);
    COV_PAGE: cover property (!mem_o.ras_n throughout
        ($fell(mem_o.cas_n) ##[2:20] $fell(mem_o.cas_n)));
    COV_REFRESH: cover property ((!mem_o.ras_n && mem_o.cas_n) [*8]);
endmodule : adc_chk

bind adc_ctrl adc_chk #(
    .PAUSE_CYC (PAUSE_CYC),
    .REF_CYC   (REF_CYC)
) u_chk (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .req_valid_i (req_valid_i),
    .req_i       (req_i),
    .req_ready_o (req_ready_o),
    .rd_valid_o  (rd_valid_o),
    .rd_data_o   (rd_data_o),
    .init_done_o (init_done_o),
    .mem_o       (mem_o),
    .mem_dq_i    (mem_dq_i)
);
`default_nettype wire

// [sim/adc_mem_model.sv]
// Behavioural 16K x 4 memory answering the controller's strobes.
// Assumes the bench resolves the shared data pins from the controller's dq_oe_n alone.
`timescale 1ns/100ps
`default_nettype none
module adc_mem_model
    import adc_pkg::*;
(
    // Pins from the controller and the answer back.
    input  var  adc_pins_t         pins_i,
    input  wire logic              slow_i,
    output logic [DATA_W-1:0]      dq_o,
    output logic                   dq_en_o,
    // Event counts for the bench.
    output logic [7:0]             wake_cnt_o,
    output logic [7:0]             ref_cnt_o,
    output logic [7:0]             page_cnt_o,
    output logic [HALF_W-1:0]      ref_row_o,
    output logic                   clash_o
);
    logic [DATA_W-1:0] mem [ROWS*ROWS];  // Word store.
    logic [HALF_W-1:0] row, col;         // Latched address halves.
    logic              open, cas_seen, any_cas;

    initial
    begin
        {dq_o, dq_en_o, wake_cnt_o, ref_cnt_o, page_cnt_o} = '0;
        {ref_row_o, clash_o, open, cas_seen, any_cas} = '0;
    end

    // Row half taken at the falling row strobe.
    always @(negedge pins_i.ras_n)
    begin
        row = pins_i.addr;
        open = 1'b1;
        cas_seen = 1'b0;
        wake_cnt_o = wake_cnt_o + {7'h00, !any_cas};
    end

    // A row cycle with no column strobe refreshes the row.
    always @(posedge pins_i.ras_n)
    begin
        if (open && !cas_seen)
        begin
            ref_cnt_o = ref_cnt_o + 8'h01;
            ref_row_o = row;
        end
        open = 1'b0;
    end

    // Early write latches at the column strobe; reads answer 20 ns
    // after the column strobe, 90 ns when slow is asked.
    always @(negedge pins_i.cas_n)
    begin
        page_cnt_o = page_cnt_o + {7'h00, cas_seen};
        cas_seen = 1'b1;
        any_cas = 1'b1;
        col = pins_i.addr;
        if (!pins_i.we_n)
        begin
            mem[{row, col}] = pins_i.dq_out;
        end
        else
        begin
            #(slow_i ? 90 : 20);
            if (!pins_i.cas_n && !pins_i.oe_n && pins_i.we_n)
            begin
                dq_o = mem[{row, col}];
                dq_en_o = 1'b1;
            end
        end
    end

    // Released pins show a changed value, never the stale word.
    always @(posedge pins_i.cas_n or posedge pins_i.oe_n)
    begin
        dq_en_o = 1'b0;
        dq_o = ~dq_o;
    end

    // Both sides driving at once is remembered.
    always @*
    begin
        if (dq_en_o && !pins_i.dq_oe_n)
        begin
            clash_o = 1'b1;
        end
    end
endmodule : adc_mem_model
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the DRAM controller and its memory model.
// Assumes short pause and refresh counts set through parameters.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import adc_pkg::*;
    localparam int PAUSE = 10;
    localparam int REFC  = 100;

    logic clk_i, rst_b_i, req_valid_i, req_ready_o, rd_valid_o;
    logic init_done_o, dq_en, clash, slow;
    adc_req_t          req_i;
    adc_pins_t         mem_o;
    logic [DATA_W-1:0] rd_data_o, mem_dq_i, mdl_dq;
    logic [7:0]        wake_cnt, ref_cnt, page_cnt;
    logic [HALF_W-1:0] ref_row;
    logic [DATA_W-1:0] rdq [$];  // Read answers in arrival order.
    int errors, samples_checked;

    // Controller wins the pins only while it drives them.
    assign mem_dq_i = !mem_o.dq_oe_n ? mem_o.dq_out : mdl_dq;

    adc_ctrl #(.PAUSE_CYC(PAUSE), .REF_CYC(REFC)) dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o),
        .rd_data_o(rd_data_o), .init_done_o(init_done_o),
        .mem_o(mem_o), .mem_dq_i(mem_dq_i));

    adc_mem_model mdl (
        .pins_i(mem_o), .slow_i(slow), .dq_o(mdl_dq), .dq_en_o(dq_en),
        .wake_cnt_o(wake_cnt), .ref_cnt_o(ref_cnt),
        .page_cnt_o(page_cnt), .ref_row_o(ref_row), .clash_o(clash));

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Collect read answers where the outputs are settled.
    always @(negedge clk_i)
    begin
        if (rd_valid_o === 1'b1)
        begin
            rdq.push_back(rd_data_o);
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    // Holds a request until taken; keeps valid up unless last is set.
    task automatic send(input logic w, pg, input logic [13:0] a,
                        input logic [3:0] d, input logic last);
        int n;
        n = 0;
        @(negedge clk_i);
        req_i = '{w, pg, a, d};
        req_valid_i = 1'b1;
        #1;
        while (req_ready_o !== 1'b1 && n < 300)
        begin
            @(negedge clk_i);
            #1;
            n++;
        end
        check(16'(n < 300), 16'h0001);
        @(posedge clk_i);
        if (last)
        begin
            @(negedge clk_i);
            req_valid_i = 1'b0;
        end
    endtask : send

    task automatic expect_rd(input logic [3:0] exp);
        int n;
        n = 0;
        while (rdq.size() == 0 && n < 60)
        begin
            @(negedge clk_i);
            n++;
        end
        check(16'(rdq.size() != 0 ? rdq.pop_front() : 4'hX), 16'(exp));
    endtask : expect_rd

    // Returns just after the model sees the next refresh; gives the wait.
    task automatic wait_ref(output int n);
        logic [7:0] c;
        c = ref_cnt;
        n = 0;
        while (ref_cnt === c && n < 400)
        begin
            @(negedge clk_i);
            n++;
        end
    endtask : wait_ref

    task automatic t_init();
        int n;
        n = 0;
        while (init_done_o !== 1'b1 && n < 400)
        begin
            @(negedge clk_i);
            n++;
        end
        check(16'(init_done_o), 16'h0001);
        check(16'(wake_cnt), 16'h0008);
    endtask : t_init

    task automatic t_rw();
        logic [13:0] a [4] = '{14'h0000, 14'h3FFF, 14'h1555, 14'h2A80};
        logic [3:0]  d [4] = '{4'h5, 4'hA, 4'hF, 4'h0};
        for (int i = 0; i < 4; i++) send(1'b1, 1'b0, a[i], d[i], 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            check(16'(mdl.mem[a[i]]), 16'(d[i]));
            send(1'b0, 1'b0, a[i], 4'h0, 1'b1);
            expect_rd(d[i]);
        end
        slow = 1'b1;
        send(1'b0, 1'b0, a[1], 4'h0, 1'b1);
        expect_rd(d[1]);
        slow = 1'b0;
    endtask : t_rw

    task automatic t_page();
        int n;
        logic [7:0] p;
        // The second refresh is never delayed by traffic, so timing is known.
        wait_ref(n);
        wait_ref(n);
        p = page_cnt;
        for (int i = 0; i < 4; i++)
            send(1'b1, 1'b1, {7'h33, 7'(i * 5)}, 4'(i + 3), i == 3);
        for (int i = 0; i < 4; i++)
            send(1'b0, 1'b1, {7'h33, 7'(i * 5)}, 4'h0, i == 3);
        for (int i = 0; i < 4; i++) expect_rd(4'(i + 3));
        check(16'(page_cnt - p), 16'h0007);
    endtask : t_page

    task automatic t_refresh();
        int n;
        logic [HALF_W-1:0] r;
        wait_ref(n);
        r = ref_row;
        wait_ref(n);
        check(16'(ref_row), 16'(r + 7'h01));
        check(16'(n <= REFC + 32), 16'h0001);
        check(16'(clash), 16'h0000);
        check(16'(dq_en), 16'h0000);
    endtask : t_refresh

    task automatic complete_run();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    initial
    begin
        {rst_b_i, req_valid_i, slow} = 3'b000;
        req_i = '0;
        errors = 0;
        samples_checked = 0;
        repeat (16) @(negedge clk_i);
        rst_b_i = 1'b1;
        t_init();
        t_rw();
        t_page();
        t_refresh();
        complete_run();
    end

    // A hang is cut off well past the several hundred cycles needed.
    initial
    begin
        repeat (20000) @(posedge clk_i);
        errors++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
